//--- design/serial_port_select_i2c_slave.sv
// strap-selected serial port front end with a two-wire register slave
`timescale 1ns/1ps
module serial_port_select_i2c_slave
  import i2c_port_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic port_select_upper_strap,
  input wire logic port_select_lower_strap,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic spi_enable,
  output logic i2c_enable,
  output logic wr_valid,
  input wire logic wr_ready,
  output reg_write_s wr_req,
  output logic [15:0] rd_addr,
  input wire logic [7:0] rd_data
);
  // scl is never driven here: no scl output exists
  typedef struct packed {
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_q;
    logic sda_q;
    logic strap_done;
    logic spi_en;
    logic i2c_en;
    logic [1:0] addr_lsb;
    slave_state_e fsm;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [1:0] idx;
    logic [15:0] ptr;
    logic past_last;
    logic wr_nack;
    logic rd_dir;
    logic sda_low;
    logic push;
    reg_write_s push_data;
  } slave_state_s;
  slave_state_s st, next_st;

  logic scl, sda, scl_rise, scl_fall, start_seen, stop_seen, fifo_ready;
  logic [6:0] own_addr;

  assign scl = st.scl_s[1];
  assign sda = st.sda_s[1];
  assign scl_rise = scl && !st.scl_q;
  assign scl_fall = !scl && st.scl_q;
  // filtered with two-flop sync; 10 ns sampling covers 400 kHz easily
  assign start_seen = scl && st.scl_q && st.sda_q && !sda;
  assign stop_seen = scl && st.scl_q && !st.sda_q && sda;
  assign own_addr = {ADDR_HIGH_BITS, st.addr_lsb};

  always_comb begin
    next_st = st;
    next_st.strap_s1 = {st.strap_s1[0], port_select_upper_strap};
    next_st.strap_s2 = {st.strap_s2[0], port_select_lower_strap};
    next_st.scl_s = {st.scl_s[0], scl_in};
    next_st.sda_s = {st.sda_s[0], sda_in};
    next_st.scl_q = scl;
    next_st.sda_q = sda;
    next_st.push = 1'b0;
    // straps caught once after reset release, once sync has settled
    if (!st.strap_done && st.bitcnt == 4'h3) begin
      next_st.strap_done = 1'b1;
      next_st.spi_en = !st.strap_s1[1] && !st.strap_s2[1];
      next_st.i2c_en = st.strap_s1[1] || st.strap_s2[1];
      // upper low/lower high -> 00, high/low -> 01, both high -> 10
      next_st.addr_lsb = {st.strap_s1[1] && st.strap_s2[1],
                          st.strap_s1[1] && !st.strap_s2[1]};
      next_st.bitcnt = 4'h0;
    end else if (!st.strap_done) begin
      next_st.bitcnt = st.bitcnt + 4'h1;
    end else if (!st.i2c_en) begin
      next_st.sda_low = 1'b0;
    end else if (start_seen) begin
      // partial byte dropped, repeated start accepted
      next_st.fsm = ST_ADDR;
      next_st.bitcnt = 4'h0;
      next_st.sda_low = 1'b0;
      next_st.idx = 2'd0;
      next_st.wr_nack = 1'b0;
    end else if (stop_seen) begin
      next_st.fsm = ST_IDLE;
      next_st.sda_low = 1'b0;
    end else begin
      case (st.fsm)
        ST_IDLE: next_st.sda_low = 1'b0;
        ST_ADDR, ST_WR_BYTE: begin
          if (scl_rise) begin
            // msb first, eight bits
            next_st.shreg = {st.shreg[6:0], sda};
            next_st.bitcnt = st.bitcnt + 4'h1;
          end else if (scl_fall && st.bitcnt == 4'h8) begin
            next_st.bitcnt = 4'h0;
            if (st.fsm == ST_ADDR) begin
              if (st.shreg[7:1] == own_addr) begin
                next_st.fsm = ST_ADDR_ACK;
                next_st.rd_dir = st.shreg[0];
                next_st.sda_low = 1'b1;
              end else begin
                next_st.fsm = ST_IDLE;
              end
            end else begin
              next_st.fsm = ST_WR_ACK;
              if (st.idx == 2'd0) begin
                next_st.ptr[15:8] = st.shreg;
                next_st.idx = 2'd1;
                next_st.sda_low = 1'b1;
              end else if (st.idx == 2'd1) begin
                // address-only write leaves the pointer loaded
                next_st.ptr[7:0] = st.shreg;
                next_st.idx = 2'd2;
                next_st.past_last = 1'b0;
                next_st.sda_low = 1'b1;
              end else if (st.wr_nack || !fifo_ready) begin
                // fifo full also nacks rather than losing data
                next_st.sda_low = 1'b0;
              end else begin
                next_st.push = 1'b1;
                next_st.push_data = '{addr: st.ptr, data: st.shreg};
                next_st.ptr = st.ptr + 16'h1;
                next_st.wr_nack = st.ptr == LAST_REG;
                next_st.sda_low = 1'b1;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            next_st.sda_low = 1'b0;
            if (st.fsm == ST_WR_ACK && !st.sda_low) begin
              next_st.fsm = ST_IDLE;
            end else if (st.rd_dir) begin
              // first data bit driven while scl low
              next_st.fsm = ST_RD_BYTE;
              next_st.shreg = st.past_last ? BLANK_BYTE : rd_data;
              next_st.sda_low = !(st.past_last ? BLANK_BYTE[7] : rd_data[7]);
              next_st.bitcnt = 4'h0;
            end else begin
              next_st.fsm = ST_WR_BYTE;
            end
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            if (st.bitcnt == 4'h7) begin
              next_st.sda_low = 1'b0;
              next_st.fsm = ST_RD_ACK;
              next_st.past_last = st.past_last || st.ptr == LAST_REG;
              next_st.ptr = st.ptr + 16'h1;
              next_st.bitcnt = 4'h0;
            end else begin
              next_st.shreg = {st.shreg[6:0], 1'b0};
              next_st.sda_low = !st.shreg[6];
              next_st.bitcnt = st.bitcnt + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            next_st.bitcnt = {3'h0, sda};
          end else if (scl_fall) begin
            if (st.bitcnt[0]) begin
              next_st.fsm = ST_IDLE;
              next_st.sda_low = 1'b0;
            end else begin
              next_st.fsm = ST_RD_BYTE;
              next_st.shreg = st.past_last ? BLANK_BYTE : rd_data;
              next_st.sda_low = !(st.past_last ? BLANK_BYTE[7] : rd_data[7]);
            end
            next_st.bitcnt = 4'h0;
          end
        end
        default: next_st.fsm = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
      st.scl_s <= 2'b11;
      st.sda_s <= 2'b11;
      st.scl_q <= 1'b1;
      st.sda_q <= 1'b1;
      st.ptr <= PTR_RESET; // kept across transfers
      st.fsm <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  write_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(st.push),
    .in_ready(fifo_ready),
    .in_data(st.push_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_req)
  );

  assign sda_out = 1'b0;
  assign sda_oe = st.sda_low;
  assign spi_enable = st.spi_en;
  assign i2c_enable = st.i2c_en;
  assign rd_addr = st.ptr;
endmodule

//--- design/i2c_port_pkg.sv
// constants and carrier types for the serial port select and two-wire slave
// Notes on behaviour
// - straps sampled at reset; both low selects SPI
// - upper five address bits fixed at 11000
// - two low address bits follow strap pins
// - works at 100 kHz and 400 kHz
// - slave only, never drives SCL
// - SDA changes only while SCL low
// - start is SDA fall while SCL high
// - stop is SDA rise while SCL high
// - eight bits MSB first, then acknowledge bit
// - ack low on ninth pulse, nack high
// - ack own address only, else idle
// - write: two address bytes high first, then data
// - read returns register data on SDA
// - unlimited bytes, address increments per byte
// - master nack ends read, SDA released
// - repeated start or stop anywhere, discard byte
// - nack data byte after write to 0x234
// - reads after register 0x234 return 0x00
// - address-only write just loads pointer
package i2c_port_pkg;
  localparam logic [4:0] ADDR_HIGH_BITS = 5'h18;
  localparam logic [15:0] LAST_REG = 16'h0234;
  localparam logic [7:0] BLANK_BYTE = 8'h00;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 24;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK
  } slave_state_e;

  // register write handed to the configuration side
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } reg_write_s;
endpackage

//--- design/write_fifo.sv
// small synchronous FIFO for register writes
`timescale 1ns/1ps
module write_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_s;
  fifo_state_s st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (st.wr - st.rd) != (AW+1)'(DEPTH);
  assign out_valid = st.wr != st.rd;
  assign out_data = mem[st.rd[AW-1:0]];

  always_comb begin
    next_st = st;
    if (push) next_st.wr = st.wr + 1'b1;
    if (pop) next_st.rd = st.rd + 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
    if (push) mem[st.wr[AW-1:0]] <= in_data;
  end
endmodule

//--- bench/bus_master.sv
// two-wire bus master model: drives SCL, pulls SDA low
`timescale 1ns/1ps
module bus_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // extra low time first: the slave may still hold its ack bit
  task automatic start();
    sda_low = 1'b0;
    #(2*Q) scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #Q sda_low = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  task automatic tx(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rx(input logic ack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(~ack, r);
  endtask
endmodule

//--- bench/serial_port_select_i2c_slave_assertions.sv
// port checks for the serial port select slave
`timescale 1ns/1ps
module serial_port_select_i2c_slave_assertions
  import i2c_port_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic port_select_upper_strap,
  input wire logic port_select_lower_strap,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic spi_enable,
  input wire logic i2c_enable,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire reg_write_s wr_req,
  input wire logic [15:0] rd_addr,
  input wire logic [7:0] rd_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sda_out_zero_a: assert property (sda_out == 1'b0) else $error("sda_out high");
  port_exclusive_a: assert property (!(spi_enable && i2c_enable)) else $error("two ports");
  spi_select_a: assert property ($rose(spi_enable) |->
    !port_select_upper_strap && !port_select_lower_strap) else $error("bad spi select");
  i2c_select_a: assert property ($rose(i2c_enable) |->
    port_select_upper_strap || port_select_lower_strap) else $error("bad i2c select");
  enables_hold_a: assert property ($past(i2c_enable) |-> i2c_enable) else $error("i2c lost");
  spi_quiet_a: assert property (!i2c_enable |-> !sda_oe) else $error("sda driven");
  oe_low_phase_a: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved");
  oe_high_stable_a: assert property ($rose(scl_in) |=> $stable(sda_oe) [*4])
    else $error("sda moved in high");
  wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_req))
    else $error("write head moved");
endmodule

//--- bench/serial_port_select_i2c_slave_tb.sv
// self-checking bench for the serial port select slave
`timescale 1ns/1ps
module serial_port_select_i2c_slave_tb;
  import i2c_port_pkg::*;
  localparam int DEPTH = 8;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic port_select_upper_strap = 1'b0;
  logic port_select_lower_strap = 1'b1;
  logic wr_ready = 1'b0;
  logic scl, sda_low, sda_out, sda_oe, spi_enable, i2c_enable, wr_valid, ack;
  logic [15:0] rd_addr;
  logic [7:0] rd_data, d;
  logic [6:0] own;
  reg_write_s wr_req;
  wire sda = ~(sda_oe | sda_low);
  int fail_count = 0;
  int total_checks = 0;
  // register file stand-in: contents follow the address
  assign rd_data = rd_addr[7:0] ^ 8'h5a;
  initial forever #5 clk_sys = ~clk_sys;
  bus_master u_bus_master (.scl(scl), .sda_low(sda_low), .sda(sda));
  serial_port_select_i2c_slave #(.DEPTH(DEPTH)) u_serial_port_select_i2c_slave (
    .clk_sys(clk_sys), .rst_n(rst_n), .port_select_upper_strap(port_select_upper_strap),
    .port_select_lower_strap(port_select_lower_strap), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .spi_enable(spi_enable), .i2c_enable(i2c_enable),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_req(wr_req), .rd_addr(rd_addr),
    .rd_data(rd_data));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic u, input logic l);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    port_select_upper_strap <= u;
    port_select_lower_strap <= l;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk_sys);
    own = {ADDR_HIGH_BITS, u & l, u & ~l};
  endtask
  task automatic set_ptr(input logic [15:0] p);
    u_bus_master.start();
    u_bus_master.tx({own, 1'b0}, ack);
    chk(ack, 1);
    u_bus_master.tx(p[15:8], ack);
    chk(ack, 1);
    u_bus_master.tx(p[7:0], ack);
    chk(ack, 1);
  endtask
  task automatic rd_start();
    u_bus_master.start();
    u_bus_master.tx({own, 1'b1}, ack);
    chk(ack, 1);
  endtask
  task automatic rd_chk(input logic more, input logic [7:0] exp);
    u_bus_master.rx(more, d);
    chk(d, exp);
  endtask
  task automatic pop_chk(input logic [23:0] exp);
    @(posedge clk_sys);
    for (int i = 0; i < 100 && wr_valid !== 1'b1; i++) @(posedge clk_sys);
    chk(wr_valid, 1);
    chk(wr_req, exp);
    wr_ready <= 1'b1;
    @(posedge clk_sys);
    wr_ready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic t_straps();
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1], i[0]);
      chk(spi_enable, i == 0);
      chk(i2c_enable, i != 0);
      for (int j = 0; j < 3; j++) begin
        u_bus_master.start();
        u_bus_master.tx({ADDR_HIGH_BITS, j[1:0], 1'b0}, ack);
        u_bus_master.stop();
        chk(ack, i != 0 && own[1:0] == j[1:0]);
      end
    end
  endtask
  // consumer stalls until the buffer refuses, then drains it
  task automatic t_fill();
    set_ptr(16'h0010);
    for (int k = 0; k < 9; k++) begin
      u_bus_master.tx(8'ha0 + k[7:0], ack);
      chk(ack, k < DEPTH);
    end
    u_bus_master.stop();
    for (int k = 0; k < DEPTH; k++) pop_chk({16'h0010 + k[15:0], 8'ha0 + k[7:0]});
    chk(wr_valid, 0);
  endtask
  task automatic t_read();
    u_bus_master.start();
    repeat (3) u_bus_master.bit_io(1'b1, ack);
    set_ptr(16'h0040);
    chk(rd_addr, 16'h0040);
    rd_start();
    rd_chk(1, 8'h40 ^ 8'h5a);
    rd_chk(0, 8'h41 ^ 8'h5a);
    u_bus_master.stop();
    chk(sda_oe, 0);
    rd_start();
    rd_chk(0, 8'h42 ^ 8'h5a);
    u_bus_master.stop();
  endtask
  task automatic t_end();
    set_ptr(LAST_REG - 16'h0001);
    for (int k = 0; k < 3; k++) begin
      u_bus_master.tx(8'h11, ack);
      chk(ack, k < 2);
    end
    u_bus_master.stop();
    pop_chk({LAST_REG - 16'h0001, 8'h11});
    pop_chk({LAST_REG, 8'h11});
    chk(wr_valid, 0);
    set_ptr(LAST_REG - 16'h0001);
    rd_start();
    rd_chk(1, 8'h33 ^ 8'h5a);
    rd_chk(1, 8'h34 ^ 8'h5a);
    rd_chk(0, BLANK_BYTE);
    u_bus_master.stop();
  endtask
  initial begin
    t_straps();
    t_fill();
    t_read();
    t_end();
    final_report();
  end
  initial begin
    #500us;
    fail_count++;
    final_report();
  end
endmodule
bind serial_port_select_i2c_slave serial_port_select_i2c_slave_assertions #(.DEPTH(DEPTH))
  u_serial_port_select_i2c_slave_assertions (.clk_sys(clk_sys), .rst_n(rst_n),
  .port_select_upper_strap(port_select_upper_strap),
  .port_select_lower_strap(port_select_lower_strap), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .spi_enable(spi_enable), .i2c_enable(i2c_enable),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_req(wr_req), .rd_addr(rd_addr),
  .rd_data(rd_data));
